// ### rtl/sep_device.sv
/*
 Serial memory device end: framing, shifting, pause, protection, write timer.
 Assumes all link pins are asynchronous to i_core_clk and sampled here.
*/
`timescale 1ns/1ps
module sep_device #(
    parameter int unsigned ADDR_W       = 16,
    parameter int unsigned DEPTH        = 256,
    parameter int unsigned WRITE_CYCLES = sep_pkg::WRITE_CYCLES
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_resetn,
    sep_link_if.device      link,
    output logic            o_busy,
    output logic [7:0]      o_status
);
    typedef enum logic [3:0] {
        SD_IDLE = 4'b0001,
        SD_CMD  = 4'b0010,
        SD_ADDR = 4'b0100,
        SD_DATA = 4'b1000
    } sd_state_t;

    typedef struct packed {
        logic [1:0]  sel_s;
        logic [1:0]  clk_s;
        logic [1:0]  di_s;
        logic [1:0]  wp_s;
        logic [1:0]  hold_s;
        logic        clk_prev;
        sd_state_t   st;
        logic [2:0]  bitc;
        logic [7:0]  shin;
        logic [7:0]  shout;
        logic [7:0]  cmd;
        logic [ADDR_W-1:0] addr;
        logic [4:0]  acnt;
        logic [7:0]  status;
        logic        wr_pend;
        logic        miso;
        logic        oe_n;
        logic [31:0] wtimer;
        logic        wmem;
        logic [ADDR_W-1:0] waddr;
        logic [7:0]  wdata;
    } sd_regs_t;

    sd_regs_t   state_reg;
    sd_regs_t   state_next;
    logic [7:0] mem [DEPTH];

    logic sel_n;
    logic sclk;
    logic hold_n;
    logic rise;
    logic fall;
    logic busy;
    logic hw_prot;
    logic [7:0] byte_in;
    assign sel_n   = state_reg.sel_s[1];
    assign sclk    = state_reg.clk_s[1];
    assign hold_n  = state_reg.hold_s[1];
    assign busy    = state_reg.status[sep_pkg::ST_BUSY_BIT];
    // Edges are dropped while paused, so the shift point survives a pause
    // Host only moves the pause while the clock is low, so no edge is lost
    assign rise    = sclk & ~state_reg.clk_prev & hold_n;
    assign fall    = ~sclk & state_reg.clk_prev & hold_n;
    assign byte_in = {state_reg.shin[6:0], state_reg.di_s[1]};
    assign hw_prot = ~state_reg.wp_s[1] & state_reg.status[sep_pkg::ST_PPE_BIT];

    always_comb begin
        state_next          = state_reg;
        state_next.sel_s    = {state_reg.sel_s[0], link.sel_n};
        state_next.clk_s    = {state_reg.clk_s[0], link.sclk};
        state_next.di_s     = {state_reg.di_s[0], link.mosi};
        state_next.wp_s     = {state_reg.wp_s[0], link.wp_n};
        state_next.hold_s   = {state_reg.hold_s[0], link.hold_n};
        state_next.clk_prev = sclk;
        state_next.wmem     = 1'b0;
        if (busy) begin
            if (state_reg.wtimer == 32'h0) begin
                state_next.status[sep_pkg::ST_BUSY_BIT] = 1'b0;
                state_next.status[sep_pkg::ST_WEL_BIT]  = 1'b0;
            end else begin
                state_next.wtimer = state_reg.wtimer - 32'h1;
            end
        end
        if (sel_n) begin
            state_next.st   = SD_IDLE;
            state_next.oe_n = 1'b1;
            state_next.bitc = 3'h0;
            if (state_reg.wr_pend) begin
                state_next.wr_pend = 1'b0;
                state_next.status[sep_pkg::ST_BUSY_BIT] = 1'b1;
                state_next.wtimer = WRITE_CYCLES - 1;
            end
        end else begin
            state_next.oe_n = ~hold_n | (state_reg.st != SD_DATA)
                              | (state_reg.cmd != sep_pkg::CMD_READ
                                 && state_reg.cmd != sep_pkg::READ_STATUS_COMMAND);
            if (state_reg.st == SD_IDLE) begin
                state_next.st = SD_CMD;
            end
            if (rise) begin
                state_next.shin = byte_in;
                state_next.bitc = state_reg.bitc + 3'h1;
                if (state_reg.bitc == 3'h7) begin
                    unique case (state_reg.st)
                        SD_CMD: begin
                            state_next.cmd = byte_in;
                            state_next.acnt = 5'h0;
                            if (busy && byte_in != sep_pkg::READ_STATUS_COMMAND) begin
                                state_next.cmd = 8'h00;
                                state_next.st  = SD_IDLE;
                            end else if (byte_in == sep_pkg::CMD_WREN) begin
                                state_next.status[sep_pkg::ST_WEL_BIT] = 1'b1;
                            end else if (byte_in == sep_pkg::CMD_WRDI) begin
                                state_next.status[sep_pkg::ST_WEL_BIT] = 1'b0;
                            end else if (byte_in == sep_pkg::CMD_READ
                                         || byte_in == sep_pkg::CMD_WRITE) begin
                                state_next.st = SD_ADDR;
                            end else begin
                                state_next.st = SD_DATA;
                                state_next.shout = state_reg.status;
                            end
                        end
                        SD_ADDR: begin
                            state_next.addr = {state_reg.addr[ADDR_W-9:0], byte_in};
                            state_next.acnt = state_reg.acnt + 5'h8;
                            if (32'(state_reg.acnt) + 8 >= ADDR_W) begin
                                state_next.st = SD_DATA;
                                // Low address byte is the one just shifted in
                                // Only the low byte indexes the small array
                                state_next.shout = mem[byte_in];
                            end
                        end
                        SD_DATA: begin
                            if (state_reg.cmd == sep_pkg::CMD_WRITE
                                && state_reg.status[sep_pkg::ST_WEL_BIT]) begin
                                state_next.wmem    = 1'b1;
                                state_next.waddr   = state_reg.addr;
                                state_next.wdata   = byte_in;
                                state_next.wr_pend = 1'b1;
                                state_next.addr    = state_reg.addr + 1'b1;
                            end else if (state_reg.cmd == sep_pkg::CMD_WRSR
                                && state_reg.status[sep_pkg::ST_WEL_BIT]
                                && !hw_prot) begin
                                state_next.status = (state_reg.status & ~sep_pkg::ST_WR_MASK)
                                                    | (byte_in & sep_pkg::ST_WR_MASK);
                                state_next.wr_pend = 1'b1;
                            end else if (state_reg.cmd == sep_pkg::CMD_READ) begin
                                state_next.addr  = state_reg.addr + 1'b1;
                                state_next.shout = mem[state_reg.addr[7:0] + 8'h01];
                            end else begin
                                state_next.shout = state_reg.status;
                            end
                        end
                        default: state_next.st = SD_IDLE;
                    endcase
                end
            end
            if (fall && state_reg.st == SD_DATA) begin
                state_next.miso  = state_reg.shout[7];
                state_next.shout = {state_reg.shout[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg        <= '0;
            state_reg.st     <= SD_IDLE;
            state_reg.sel_s  <= 2'h3;
            state_reg.oe_n   <= 1'b1;
            state_reg.status <= sep_pkg::ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Array has no reset; contents are undefined until written
    always_ff @(posedge i_core_clk) begin
        if (state_reg.wmem) begin
            mem[state_reg.waddr[7:0]] <= state_reg.wdata;
        end
    end

    assign link.miso      = state_reg.miso;
    assign link.miso_oe_n = state_reg.oe_n;
    assign o_busy         = busy;
    assign o_status       = state_reg.status;
endmodule : sep_device

// ### rtl/sep_pkg.sv
/*
 Constants shared by both ends of the serial memory link.
 Assumes both ends run on one 25 MHz core clock; the link clock is sampled.
*/
// Operation
// - Device samples data on serial clock rise
// - Device changes output on serial clock fall
// - Select high: output off, standby unless writing
// - Host frames each transaction with select low
// - Protect pin high never blocks writes
// - Protect low plus enable bit: status write rejected
// - Pause suspends, release resumes same point
// - Host changes pause only while clock low
// - Host ties pause high when unused
// - Output off while paused, driven after
// - Internal write finishes within 5 ms
// - Host waits 1 ms after power-up
// - Hardware protection needs pin low and bit
// - During write only status read accepted
package sep_pkg;
    localparam int unsigned CORE_CLK_HZ         = 25_000_000;
    localparam int unsigned WRITE_CYCLE_TIME_MS = 5;
    localparam int unsigned POWER_UP_TIME_MS    = 1;
    localparam int unsigned WRITE_CYCLES =
        (CORE_CLK_HZ / 1000) * WRITE_CYCLE_TIME_MS;
    localparam int unsigned POWER_UP_CYCLES =
        (CORE_CLK_HZ / 1000) * POWER_UP_TIME_MS;
    localparam int unsigned HALF_PERIOD_CYCLES  = 4;
    localparam logic [7:0] CMD_WREN  = 8'h06;
    localparam logic [7:0] CMD_WRDI  = 8'h04;
    localparam logic [7:0] READ_STATUS_COMMAND = 8'h05;
    localparam logic [7:0] CMD_WRSR  = 8'h01;
    localparam logic [7:0] CMD_READ  = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_WEL_BIT  = 1;
    localparam int unsigned ST_PPE_BIT  = 7;
    localparam logic [7:0]  ST_WR_MASK  = 8'h9c;
    localparam logic [7:0]  ST_RESET    = 8'h00;
endpackage : sep_pkg

// ### rtl/sep_link_if.sv
/*
 Pin bundle between host end and device end.
 Assumes the bench resolves the data output from its enable.
*/
`timescale 1ns/1ps
interface sep_link_if;
    logic sel_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic wp_n;
    logic hold_n;
    modport host (output sel_n, sclk, mosi, wp_n, hold_n, input miso, miso_oe_n);
    modport device (input sel_n, sclk, mosi, wp_n, hold_n, output miso, miso_oe_n);
endinterface : sep_link_if

// ### rtl/sep_host.sv
/*
 Host end: frames one transaction of one to seven bytes, makes the link clock.
 Assumes the user holds request data stable while busy.
*/
`timescale 1ns/1ps
module sep_host #(
    parameter int unsigned POWER_UP_CYCLES = sep_pkg::POWER_UP_CYCLES,
    parameter int unsigned HALF_CYCLES     = sep_pkg::HALF_PERIOD_CYCLES
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    sep_link_if.host         link,
    input  wire logic        i_start,
    input  wire logic [2:0]  i_nbytes,
    input  wire logic [31:0] i_tx,
    input  wire logic        i_pause,
    input  wire logic        i_wp_n,
    output logic             o_ready,
    output logic             o_done,
    output logic [31:0]      o_rx
);
    typedef enum logic [2:0] {
        SH_WAIT = 3'b001,
        SH_IDLE = 3'b010,
        SH_XFER = 3'b100
    } sh_state_t;

    typedef struct packed {
        sh_state_t   st;
        logic [31:0] cnt;
        logic [5:0]  bits;
        logic [31:0] tx;
        logic [31:0] rx;
        logic [1:0]  so_s;
        logic        sclk;
        logic        sel_n;
        logic        hold_n;
        logic        done;
    } sh_regs_t;

    sh_regs_t state_reg;
    sh_regs_t state_next;

    always_comb begin
        state_next      = state_reg;
        state_next.so_s = {state_reg.so_s[0], link.miso};
        state_next.done = 1'b0;
        unique case (state_reg.st)
            SH_WAIT: begin
                state_next.cnt = state_reg.cnt + 32'h1;
                if (state_reg.cnt >= POWER_UP_CYCLES - 1) begin
                    state_next.st = SH_IDLE;
                end
            end
            SH_IDLE: begin
                state_next.hold_n = 1'b1;
                if (i_start && i_nbytes != 3'h0) begin
                    state_next.st    = SH_XFER;
                    state_next.sel_n = 1'b0;
                    state_next.tx    = i_tx;
                    state_next.bits  = {i_nbytes, 3'h0};
                    state_next.cnt   = 32'h0;
                end
            end
            SH_XFER: begin
                if (!state_reg.sclk) begin
                    state_next.hold_n = ~i_pause;
                end
                // A pause change holds the clock still for that cycle
                if (state_reg.hold_n && state_next.hold_n) begin
                    state_next.cnt = state_reg.cnt + 32'h1;
                    if (state_reg.cnt == HALF_CYCLES - 1) begin
                        state_next.cnt = 32'h0;
                        if (state_reg.bits == 6'h0) begin
                            state_next.sel_n = 1'b1;
                            state_next.st    = SH_IDLE;
                            state_next.done  = 1'b1;
                        end else if (!state_reg.sclk) begin
                            state_next.sclk = 1'b1;
                        end else begin
                            // Sampled late: the answer lags the fall by the device's sync
                            state_next.rx   = {state_reg.rx[30:0], state_reg.so_s[1]};
                            state_next.sclk = 1'b0;
                            state_next.tx   = {state_reg.tx[30:0], 1'b0};
                            state_next.bits = state_reg.bits - 6'h1;
                        end
                    end
                end
            end
            default: state_next.st = SH_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg        <= '0;
            state_reg.st     <= SH_WAIT;
            state_reg.sel_n  <= 1'b1;
            state_reg.hold_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.sel_n  = state_reg.sel_n;
    assign link.sclk   = state_reg.sclk;
    assign link.mosi   = state_reg.tx[31];
    assign link.hold_n = state_reg.hold_n;
    assign link.wp_n   = i_wp_n;
    assign o_ready     = (state_reg.st == SH_IDLE);
    assign o_done      = state_reg.done;
    assign o_rx        = state_reg.rx;
endmodule : sep_host

// ### bench/sep_link_properties.sv
/*
 Pin-level properties of the link between host end and device end.
 Assumes plain copies of the link signals plus the core clock and reset.
*/
`timescale 1ns/1ps
module sep_link_properties (
    input  wire logic i_core_clk,
    input  wire logic i_resetn,
    input  wire logic sel_n,
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic miso_oe_n,
    input  wire logic wp_n,
    input  wire logic hold_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // Remembers whether the output was on when the pause began
    logic drove_reg;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            drove_reg <= 1'b0;
        end else if (hold_n) begin
            drove_reg <= !miso_oe_n;
        end
    end
    sequence s_deselected;
        sel_n[*6];
    endsequence
    sequence s_paused;
        (!hold_n)[*5];
    endsequence
    sequence s_pause_end;
        $rose(hold_n) && !sel_n && drove_reg;
    endsequence
    property p_idle_clk;
        sel_n |-> !sclk;
    endproperty
    property p_release_on_deselect;
        $rose(sel_n) |-> ##[1:6] miso_oe_n;
    endproperty
    property p_off_deselected;
        s_deselected |-> miso_oe_n;
    endproperty
    property p_off_paused;
        s_paused |-> miso_oe_n;
    endproperty
    property p_resume_drive;
        s_pause_end |-> ##[1:8] !miso_oe_n;
    endproperty
    // Device reacts a few cycles late, so check that the clock was low two cycles back
    property p_miso_after_fall;
        !miso_oe_n && $past(!miso_oe_n) && $changed(miso) |-> !$past(sclk, 2);
    endproperty
    property p_mosi_low_clk;
        $changed(mosi) && !sel_n |-> !sclk;
    endproperty
    property p_pause_clk_low;
        $changed(hold_n) |-> !sclk;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock moves outside frame");
    a_release_on_deselect: assert property (p_release_on_deselect)
        else $error("output still on after deselect");
    a_off_deselected: assert property (p_off_deselected) else $error("output on while idle");
    a_off_paused: assert property (p_off_paused) else $error("output on while paused");
    a_resume_drive: assert property (p_resume_drive) else $error("output not back");
    a_miso_after_fall: assert property (p_miso_after_fall)
        else $error("output changed after rising clock");
    a_mosi_low_clk: assert property (p_mosi_low_clk) else $error("data moved, clock high");
    a_pause_clk_low: assert property (p_pause_clk_low) else $error("pause moved, clock high");
endmodule : sep_link_properties

// ### bench/tb_top.sv
/*
 Self-checking bench: host end and device end joined by one link.
 Assumes shortened write and power-up counts; results checked from a queue.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
    localparam int unsigned WC = 400;
    localparam int unsigned PU = 10;
    localparam logic [31:0] STAT_RD = {sep_pkg::READ_STATUS_COMMAND, 24'h0};
    localparam logic [31:0] EN_WR   = {sep_pkg::CMD_WREN, 24'h0};
    logic        i_core_clk = 1'b0;
    logic        i_resetn   = 1'b0;
    logic        start      = 1'b0;
    logic [2:0]  nbytes     = 3'h0;
    logic [31:0] tx         = 32'h0;
    logic        pause      = 1'b0;
    logic        wp_n       = 1'b1;
    logic        ready, done, busy;
    logic [7:0]  status;
    logic [31:0] rx, e, m, d, a;
    logic [31:0] q_exp[$], q_msk[$];
    int          err_count  = 0;
    int          n_checks   = 0;
    int          cnt;
    always #20 i_core_clk = ~i_core_clk;
    sep_link_if sep_link_if_i ();
    sep_host #(.POWER_UP_CYCLES(PU)) sep_host_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .link(sep_link_if_i), .i_start(start), .i_nbytes(nbytes), .i_tx(tx), .i_pause(pause),
        .i_wp_n(wp_n), .o_ready(ready), .o_done(done), .o_rx(rx));
    sep_device #(.WRITE_CYCLES(WC)) sep_device_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .link(sep_link_if_i), .o_busy(busy), .o_status(status));
    sep_link_properties sep_link_properties_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .sel_n(sep_link_if_i.sel_n), .sclk(sep_link_if_i.sclk), .mosi(sep_link_if_i.mosi),
        .miso(sep_link_if_i.miso), .miso_oe_n(sep_link_if_i.miso_oe_n),
        .wp_n(sep_link_if_i.wp_n), .hold_n(sep_link_if_i.hold_n));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    // One framed transfer; pz > 0 pauses that many cycles after the start
    task automatic xfer(input logic [2:0] n, input logic [31:0] t, input logic [31:0] ex,
                        input logic [31:0] mk, input int pz);
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 1000) begin
            @(negedge i_core_clk);
            k++;
        end
        if (k >= 1000) begin
            err_count++;
            $display("mismatch at %0t: host never ready", $time);
        end
        q_exp.push_back(ex);
        q_msk.push_back(mk);
        @(posedge i_core_clk);
        start  <= 1'b1;
        nbytes <= n;
        tx     <= t;
        @(posedge i_core_clk);
        start  <= 1'b0;
        if (pz > 0) begin
            repeat (pz) @(posedge i_core_clk);
            pause <= 1'b1;
            repeat (5 + $urandom_range(15)) @(posedge i_core_clk);
            pause <= 1'b0;
        end
        k = 0;
        while (done !== 1'b1 && k < 1000) begin
            @(negedge i_core_clk);
            k++;
        end
        if (k >= 1000) begin
            err_count++;
            $display("mismatch at %0t: transfer never done", $time);
        end
    endtask : xfer
    // Write cycle must start after the frame and end inside the shortened limit
    task automatic wait_idle();
        repeat (6) @(negedge i_core_clk);
        `CHK(busy, 1'b1)
        cnt = 0;
        while (busy !== 1'b0 && cnt < 1000) begin
            @(negedge i_core_clk);
            cnt++;
        end
        `CHK(cnt <= WC, 1'b1)
    endtask : wait_idle
    always @(negedge i_core_clk) begin
        if (done === 1'b1) begin
            if (q_exp.size() == 0) begin
                err_count++;
                $display("mismatch at %0t: result with no note", $time);
            end else begin
                e = q_exp.pop_front();
                m = q_msk.pop_front();
                if (m != 32'h0) `CHK(rx & m, e)
            end
        end
    end
    initial begin
        #2_000_000;
        err_count++;
        $display("mismatch at %0t: watchdog ran out", $time);
        give_verdict();
    end
    initial begin
        void'($urandom(32'h18ce));
        repeat (4) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        cnt = 0;
        while (ready !== 1'b1 && cnt < 1000) begin
            @(negedge i_core_clk);
            cnt++;
        end
        `CHK(ready, 1'b1)
        `CHK(cnt >= PU - 1, 1'b1)
        $display("test power-up wait done");
        xfer(3'h2, STAT_RD, 32'h00, 32'hff, 0);
        xfer(3'h1, EN_WR, 32'h0, 32'h0, 0);
        xfer(3'h2, STAT_RD, 32'h02, 32'hff, 0);
        xfer(3'h1, {sep_pkg::CMD_WRDI, 24'h0}, 32'h0, 32'h0, 0);
        xfer(3'h2, STAT_RD, 32'h00, 32'hff, 0);
        $display("test write enable done");
        d = 32'h80 | ($urandom & 32'h1c);
        xfer(3'h1, EN_WR, 32'h0, 32'h0, 0);
        xfer(3'h2, {sep_pkg::CMD_WRSR, d[7:0], 16'h0}, 32'h0, 32'h0, 0);
        xfer(3'h2, STAT_RD, 32'h01, 32'h01, 0);
        // Would clear the value just written if taken while busy
        xfer(3'h2, {sep_pkg::CMD_WRSR, 24'h0}, 32'h0, 32'h0, 0);
        wait_idle();
        xfer(3'h2, STAT_RD, d & 32'h9c, 32'hff, 70 + $urandom_range(40));
        $display("test status write done");
        xfer(3'h1, EN_WR, 32'h0, 32'h0, 0);
        @(posedge i_core_clk);
        wp_n <= 1'b0;
        xfer(3'h2, {sep_pkg::CMD_WRSR, 24'h0}, 32'h0, 32'h0, 0);
        repeat (8) @(negedge i_core_clk);
        `CHK(busy, 1'b0)
        xfer(3'h2, STAT_RD, 32'h80, 32'h81, 0);
        @(posedge i_core_clk);
        wp_n <= 1'b1;
        xfer(3'h1, EN_WR, 32'h0, 32'h0, 0);
        xfer(3'h2, {sep_pkg::CMD_WRSR, 24'h0}, 32'h0, 32'h0, 0);
        wait_idle();
        xfer(3'h2, STAT_RD, 32'h00, 32'hff, 0);
        $display("test protect pin done");
        a = $urandom;
        d = $urandom;
        xfer(3'h1, EN_WR, 32'h0, 32'h0, 0);
        xfer(3'h4, {sep_pkg::CMD_WRITE, a[15:0], d[7:0]}, 32'h0, 32'h0, 0);
        wait_idle();
        xfer(3'h4, {sep_pkg::CMD_READ, a[15:0], 8'h0}, {24'h0, d[7:0]}, 32'hff,
             80 + $urandom_range(60));
        $display("test memory write and read done");
        give_verdict();
    end
endmodule : tb_top
